// ---- design/dram_cmd_decode.sv ----
module dram_cmd_decode (
	input wire logic clock,
	input wire logic reset,
	input wire logic ck,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic [dram_cmd_pkg::CA_W-1:0] ca,
	input wire logic ops_busy,
	input wire logic mr_busy,
	input wire logic init_done,
	output logic cmd_ready,
	output logic dpd_active,
	output logic low_current,
	output logic rx_enable,
	output logic drv_enable,
	output logic core_pwr_enable,
	output logic array_lost,
	output logic power_on_state,
	output logic illegal_event,
	output logic nop_seen,
	output logic mrw_valid,
	output logic [dram_cmd_pkg::MA_W-1:0] mrw_addr,
	output logic [dram_cmd_pkg::OP_W-1:0] mrw_op,
	output logic act_valid,
	output logic [dram_cmd_pkg::BANK_W-1:0] act_bank,
	output logic [dram_cmd_pkg::ROW_W-1:0] act_row
);
	typedef struct packed {
		logic rst_out;
		logic [dram_cmd_pkg::EV_N-1:0] tg_s1;
		logic [dram_cmd_pkg::EV_N-1:0] tg_s2;
		logic [dram_cmd_pkg::EV_N-1:0] tg_s3;
		logic stop_flag;
		logic [dram_cmd_pkg::WD_W-1:0] wd_cnt;
		logic [dram_cmd_pkg::TXP_W-1:0] txp_cnt;
		logic txp_run;
		dram_cmd_pkg::core_state_e state;
		logic ready;
		logic dpd_active;
		logic low_current;
		logic rx_en;
		logic drv_en;
		logic pwr_en;
		logic array_lost;
		logic power_on;
		logic illegal;
		logic nop_seen;
		logic mrw_valid;
		logic act_valid;
		dram_cmd_pkg::mrw_s mrw;
		dram_cmd_pkg::act_s act;
	} core_s;

	core_s q_reg;
	core_s q_next;
	logic [dram_cmd_pkg::EV_N-1:0] ev;

	link_evt_if evt();

	ca_link_capture u_link (
		.ck(ck),
		.cke(cke),
		.cs_n(cs_n),
		.ca(ca),
		.evt(evt)
	);

	assign evt.stop_flag = q_reg.stop_flag;
	assign evt.core_rst = q_reg.rst_out;

	// Toggle edges, taken behind two synchroniser stages
	assign ev = q_reg.tg_s2 ^ q_reg.tg_s3;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		q_next = q_reg;
		q_next.rst_out = reset;
		q_next.tg_s1 = evt.tgl;
		q_next.tg_s2 = q_reg.tg_s1;
		q_next.tg_s3 = q_reg.tg_s2;
		q_next.array_lost = 1'b0;
		q_next.nop_seen = 1'b0;
		q_next.mrw_valid = 1'b0;
		q_next.act_valid = 1'b0;

		// Heartbeat watchdog: no link edges means a stopped clock
		if (ev[dram_cmd_pkg::EV_HB]) begin
			q_next.wd_cnt = '0;
		end else if (q_reg.wd_cnt != dram_cmd_pkg::CLK_STOP_CYC) begin
			q_next.wd_cnt = q_reg.wd_cnt + 1'b1;
		end
		if (q_reg.wd_cnt == dram_cmd_pkg::CLK_STOP_CYC) begin
			q_next.stop_flag = 1'b1;
			q_next.ready = 1'b0; // RULE_15
			q_next.txp_run = 1'b0;
		end

		// Two good link periods, then the exit delay
		if (ev[dram_cmd_pkg::EV_PW_OK]) begin
			q_next.stop_flag = 1'b0; // RULE_11
			q_next.txp_run = 1'b1;
			q_next.txp_cnt = dram_cmd_pkg::TXP_CYC;
		end else if (q_reg.txp_run) begin
			if (q_reg.txp_cnt == '0) begin
				q_next.txp_run = 1'b0;
				q_next.ready = 1'b1; // RULE_15
			end else begin
				q_next.txp_cnt = q_reg.txp_cnt - 1'b1;
			end
		end

		case (q_reg.state)
			dram_cmd_pkg::ST_POWER_ON: begin
				// The init sequence or a DPD entry event brings us out
				if (init_done) begin
					q_next.state = dram_cmd_pkg::ST_IDLE; // RULE_08
					q_next.power_on = 1'b0;
					q_next.illegal = 1'b0; // RULE_20
				end
			end
			dram_cmd_pkg::ST_IDLE: begin
				q_next.state = dram_cmd_pkg::ST_IDLE;
			end
			dram_cmd_pkg::ST_DRAIN: begin
				// Low current only once running work is done
				if (!ops_busy) begin
					q_next.state = dram_cmd_pkg::ST_DPD; // RULE_04
					q_next.low_current = 1'b1;
					q_next.drv_en = 1'b0; // RULE_06
					q_next.pwr_en = 1'b0; // RULE_06
				end
			end
			dram_cmd_pkg::ST_DPD: begin
				q_next.state = dram_cmd_pkg::ST_DPD; // RULE_25
			end
			default: begin
				q_next.state = dram_cmd_pkg::ST_POWER_ON;
			end
		endcase

		// NOP changes no state: bursts and bank work carry on
		if (ev[dram_cmd_pkg::EV_NOP]) begin
			q_next.nop_seen = 1'b1; // RULE_19
		end

		if (ev[dram_cmd_pkg::EV_MRW]) begin
			if (!q_reg.ready) begin
				q_next.illegal = 1'b1; // RULE_15
			end else begin
				q_next.mrw_valid = 1'b1; // RULE_21
				q_next.mrw = evt.mrw;
			end
		end

		if (ev[dram_cmd_pkg::EV_ACT]) begin
			if (!q_reg.ready ||
				q_reg.state == dram_cmd_pkg::ST_POWER_ON) begin
				q_next.illegal = 1'b1; // RULE_08
			end else begin
				q_next.act_valid = 1'b1; // RULE_22
				q_next.act = evt.act;
			end
		end

		if (ev[dram_cmd_pkg::EV_BAD]) begin
			q_next.illegal = 1'b1; // RULE_02
		end

		if (ev[dram_cmd_pkg::EV_DPD_IN]) begin
			if (mr_busy) begin
				q_next.illegal = 1'b1; // RULE_03
			end
			q_next.state = dram_cmd_pkg::ST_DRAIN; // RULE_01
			q_next.dpd_active = 1'b1;
			q_next.array_lost = 1'b1; // RULE_05
			q_next.rx_en = 1'b0; // RULE_06
		end

		// Exit lands in power-on; clock must already be stable
		if (ev[dram_cmd_pkg::EV_DPD_OUT]) begin
			q_next.state = dram_cmd_pkg::ST_POWER_ON; // RULE_07
			q_next.power_on = 1'b1; // RULE_25
			q_next.dpd_active = 1'b0;
			q_next.low_current = 1'b0;
			q_next.rx_en = 1'b1;
			q_next.drv_en = 1'b1;
			q_next.pwr_en = 1'b1;
		end

		// Synchronous reset; toggle syncs keep tracking so no
		// stale edge appears on release
		if (reset) begin
			q_next.tg_s3 = q_reg.tg_s2;
			q_next.stop_flag = 1'b1;
			q_next.wd_cnt = '0;
			q_next.txp_cnt = '0;
			q_next.txp_run = 1'b0;
			q_next.state = dram_cmd_pkg::ST_POWER_ON;
			q_next.ready = 1'b0;
			q_next.dpd_active = 1'b0;
			q_next.low_current = 1'b0;
			q_next.rx_en = 1'b1;
			q_next.drv_en = 1'b1;
			q_next.pwr_en = 1'b1;
			q_next.array_lost = 1'b0;
			q_next.power_on = 1'b1;
			q_next.illegal = 1'b0;
			q_next.nop_seen = 1'b0;
			q_next.mrw_valid = 1'b0;
			q_next.act_valid = 1'b0;
			q_next.mrw = '0;
			q_next.act = '0;
		end
	end

	always_ff @(posedge clock) begin
		q_reg <= q_next;
	end

	////////////////////////////////////////////////////////////////////
	assign cmd_ready = q_reg.ready;
	assign dpd_active = q_reg.dpd_active;
	assign low_current = q_reg.low_current;
	assign rx_enable = q_reg.rx_en;
	assign drv_enable = q_reg.drv_en;
	assign core_pwr_enable = q_reg.pwr_en;
	assign array_lost = q_reg.array_lost;
	assign power_on_state = q_reg.power_on;
	assign illegal_event = q_reg.illegal;
	assign nop_seen = q_reg.nop_seen;
	assign mrw_valid = q_reg.mrw_valid;
	assign mrw_addr = q_reg.mrw.addr;
	assign mrw_op = q_reg.mrw.op;
	assign act_valid = q_reg.act_valid;
	assign act_bank = q_reg.act.bank;
	assign act_row = q_reg.act.row;
endmodule

// ---- design/dram_cmd_pkg.sv ----
// What the document requires
// (RULE_01) DPD entry: CKE falls, CS_n low, CA=011
// (RULE_02) Controller sends NOP cycle after DPD entry
// (RULE_03) No DPD entry during mode register access
// (RULE_04) Accept DPD entry, finish running ops first
// (RULE_05) Array contents lost on DPD entry
// (RULE_06) In DPD only CKE receiver stays alive
// (RULE_07) Exit: CKE high, stable clock, setup met
// (RULE_08) Full power-up init required after exit
// (RULE_09) CKE-low clock change: ACT/PRE all finished
// (RULE_10) Keep clock two cycles after CKE falls
// (RULE_11) Two good clock cycles before CKE rises
// (RULE_12) Every clock period within min/max limits
// (RULE_13) Stopped clock: true low, complement high
// (RULE_14) CKE-high clock change: idle, CS_n high
// (RULE_15) Ready after two good periods plus exit delay
// (RULE_16) Rewrite latency settings after frequency change
// (RULE_17) NOP only with CKE steady over two edges
// (RULE_18) NOP: CS_n high, or CA0-2 all high
// (RULE_19) NOP never cancels operations under way
// (RULE_20) Illegal event needs power-down and reinit
// (RULE_21) Mode register write two-phase field decode
// (RULE_22) Activate two-phase row and bank decode
// (RULE_23) CS_n, CKE, command sampled on rising edge
// (RULE_24) Second CA phase taken on falling edge
// (RULE_25) Hold DPD until CKE high, then power-on
// (RULE_26) Controller tracks outstanding work per device
package dram_cmd_pkg;
	localparam int CA_W = 10;
	localparam int ROW_W = 15;
	localparam int BANK_W = 3;
	localparam int MA_W = 8;
	localparam int OP_W = 8;
	localparam int MA_LO_W = 6;
	localparam int MA_HI_W = 2;
	localparam int ROW_HI_W = 5;
	localparam int ROW_LO_W = 8;

	localparam int MRW_MA_LO_POS = 4;
	localparam int MRW_MA_HI_POS = 0;
	localparam int MRW_OP_POS = 2;
	localparam int ACT_ROW_HI_POS = 2;
	localparam int ACT_BANK_POS = 7;
	localparam int ACT_ROW_LO_POS = 0;
	localparam int ACT_R13_POS = 8;
	localparam int ACT_R14_POS = 9;

	localparam logic [3:0] MRW_CODE = 4'h0;
	localparam logic [1:0] ACT_CODE = 2'h2;
	localparam logic [2:0] DPD_CODE = 3'h3;
	localparam logic [2:0] NOP_CODE = 3'h7;

	// Event toggles from the link side
	localparam int EV_MRW = 0;
	localparam int EV_ACT = 1;
	localparam int EV_NOP = 2;
	localparam int EV_BAD = 3;
	localparam int EV_DPD_IN = 4;
	localparam int EV_DPD_OUT = 5;
	localparam int EV_PW_OK = 6;
	localparam int EV_HB = 7;
	localparam int EV_N = 8;

	localparam int CORE_MHZ = 125;
	localparam int CLK_STOP_NS = 100;
	localparam int TXP_NS = 10;
	localparam int WD_W = 4;
	localparam int TXP_W = 4;
	// Longest gap: round down
	localparam logic [WD_W-1:0] CLK_STOP_CYC =
		WD_W'(CLK_STOP_NS * CORE_MHZ / 1000);
	// Least time: round up, at least one cycle
	localparam int TXP_RAW = (TXP_NS * CORE_MHZ + 999) / 1000;
	localparam logic [TXP_W-1:0] TXP_CYC =
		TXP_W'(TXP_RAW < 1 ? 1 : TXP_RAW);
	localparam logic [1:0] PW_GOOD_CYC = 2'h2;

	typedef enum logic [1:0] {
		ST_POWER_ON = 2'b00,
		ST_IDLE = 2'b01,
		ST_DRAIN = 2'b10,
		ST_DPD = 2'b11
	} core_state_e;

	typedef struct packed {
		logic [MA_W-1:0] addr;
		logic [OP_W-1:0] op;
	} mrw_s;

	typedef struct packed {
		logic [BANK_W-1:0] bank;
		logic [ROW_W-1:0] row;
	} act_s;

	function automatic logic is_nop(input logic cs,
		input logic [CA_W-1:0] c);
		return cs || (c[2:0] == NOP_CODE); // RULE_18
	endfunction

	function automatic logic is_dpd(input logic [CA_W-1:0] c);
		return c[2:0] == DPD_CODE;
	endfunction

	function automatic logic is_mrw(input logic [CA_W-1:0] c);
		return c[3:0] == MRW_CODE;
	endfunction

	function automatic logic is_act(input logic [CA_W-1:0] c);
		return c[1:0] == ACT_CODE;
	endfunction
endpackage

// ---- design/link_evt_if.sv ----
interface link_evt_if;
	logic [dram_cmd_pkg::EV_N-1:0] tgl;
	dram_cmd_pkg::mrw_s mrw;
	dram_cmd_pkg::act_s act;
	logic stop_flag;
	logic core_rst;
	modport link(
		output tgl,
		output mrw,
		output act,
		input stop_flag,
		input core_rst
	);
	modport core(
		input tgl,
		input mrw,
		input act,
		output stop_flag,
		output core_rst
	);
endinterface

// ---- design/ca_link_capture.sv ----
module ca_link_capture (
	input wire logic ck,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic [dram_cmd_pkg::CA_W-1:0] ca,
	link_evt_if.link evt
);
	typedef struct packed {
		logic rst_s1;
		logic rst_s2;
		logic stop_s1;
		logic stop_s2;
		logic cke_prev;
		logic in_dpd;
		logic chk_nop;
		logic pend_mrw;
		logic pend_act;
		logic [dram_cmd_pkg::CA_W-1:0] rise_ca;
		logic [1:0] pw_cnt;
		logic pw_sent;
		logic [dram_cmd_pkg::EV_N-1:0] tgl;
		dram_cmd_pkg::mrw_s mrw;
		dram_cmd_pkg::act_s act;
	} link_s;

	link_s q_reg;
	link_s q_next;
	logic [dram_cmd_pkg::CA_W-1:0] fall_reg;

	////////////////////////////////////////////////////////////////////
	// Second phase on the falling edge, data only
	always_ff @(negedge ck) begin
		fall_reg <= ca; // RULE_24
	end

	////////////////////////////////////////////////////////////////////
	always_comb begin
		q_next = q_reg;
		q_next.rst_s1 = evt.core_rst;
		q_next.rst_s2 = q_reg.rst_s1;
		q_next.stop_s1 = evt.stop_flag;
		q_next.stop_s2 = q_reg.stop_s1;
		q_next.cke_prev = cke; // RULE_23
		q_next.rise_ca = ca; // RULE_23
		q_next.pend_mrw = 1'b0;
		q_next.pend_act = 1'b0;
		q_next.chk_nop = 1'b0;
		q_next.tgl[dram_cmd_pkg::EV_HB] = ~q_reg.tgl[dram_cmd_pkg::EV_HB];

		// Rising phase plus the falling phase just captured
		if (q_reg.pend_mrw) begin
			q_next.mrw.addr = {
				fall_reg[dram_cmd_pkg::MRW_MA_HI_POS +: dram_cmd_pkg::MA_HI_W],
				q_reg.rise_ca[dram_cmd_pkg::MRW_MA_LO_POS +:
					dram_cmd_pkg::MA_LO_W]}; // RULE_21
			q_next.mrw.op =
				fall_reg[dram_cmd_pkg::MRW_OP_POS +: dram_cmd_pkg::OP_W];
			q_next.tgl[dram_cmd_pkg::EV_MRW] =
				~q_reg.tgl[dram_cmd_pkg::EV_MRW];
		end
		if (q_reg.pend_act) begin
			q_next.act.bank = q_reg.rise_ca[dram_cmd_pkg::ACT_BANK_POS +:
				dram_cmd_pkg::BANK_W]; // RULE_22
			q_next.act.row = {
				fall_reg[dram_cmd_pkg::ACT_R14_POS],
				fall_reg[dram_cmd_pkg::ACT_R13_POS],
				q_reg.rise_ca[dram_cmd_pkg::ACT_ROW_HI_POS +:
					dram_cmd_pkg::ROW_HI_W],
				fall_reg[dram_cmd_pkg::ACT_ROW_LO_POS +:
					dram_cmd_pkg::ROW_LO_W]}; // RULE_22
			q_next.tgl[dram_cmd_pkg::EV_ACT] =
				~q_reg.tgl[dram_cmd_pkg::EV_ACT];
		end

		// Edge after entry must carry a NOP pattern
		if (q_reg.chk_nop && !dram_cmd_pkg::is_nop(cs_n, ca)) begin
			q_next.tgl[dram_cmd_pkg::EV_BAD] =
				~q_reg.tgl[dram_cmd_pkg::EV_BAD]; // RULE_02
		end

		if (q_reg.in_dpd) begin
			// CS_n and CA receivers are off here
			if (cke) begin
				q_next.in_dpd = 1'b0; // RULE_25
				q_next.tgl[dram_cmd_pkg::EV_DPD_OUT] =
					~q_reg.tgl[dram_cmd_pkg::EV_DPD_OUT]; // RULE_07
			end
		end else if (q_reg.cke_prev && !cke && !cs_n &&
			dram_cmd_pkg::is_dpd(ca)) begin
			q_next.in_dpd = 1'b1; // RULE_01
			q_next.chk_nop = 1'b1;
			q_next.tgl[dram_cmd_pkg::EV_DPD_IN] =
				~q_reg.tgl[dram_cmd_pkg::EV_DPD_IN];
		end else if (q_reg.cke_prev && cke) begin
			if (dram_cmd_pkg::is_nop(cs_n, ca)) begin
				q_next.tgl[dram_cmd_pkg::EV_NOP] =
					~q_reg.tgl[dram_cmd_pkg::EV_NOP]; // RULE_17
			end else if (dram_cmd_pkg::is_mrw(ca)) begin
				q_next.pend_mrw = 1'b1; // RULE_21
			end else if (dram_cmd_pkg::is_act(ca)) begin
				q_next.pend_act = 1'b1; // RULE_22
			end
		end

		// Count good cycles once the core reports a stop
		if (!q_reg.stop_s2) begin
			q_next.pw_cnt = 2'h0;
			q_next.pw_sent = 1'b0;
		end else if (!q_reg.pw_sent) begin
			if (q_reg.pw_cnt == dram_cmd_pkg::PW_GOOD_CYC - 2'h1) begin
				q_next.pw_sent = 1'b1; // RULE_11
				q_next.tgl[dram_cmd_pkg::EV_PW_OK] =
					~q_reg.tgl[dram_cmd_pkg::EV_PW_OK];
			end else begin
				q_next.pw_cnt = q_reg.pw_cnt + 2'h1;
			end
		end

		if (q_reg.rst_s2) begin
			q_next.cke_prev = 1'b0;
			q_next.in_dpd = 1'b0;
			q_next.chk_nop = 1'b0;
			q_next.pend_mrw = 1'b0;
			q_next.pend_act = 1'b0;
			q_next.pw_cnt = 2'h0;
			q_next.pw_sent = 1'b0;
			q_next.tgl = '0;
			q_next.mrw = '0;
			q_next.act = '0;
		end
	end

	always_ff @(posedge ck) begin
		q_reg <= q_next;
	end

	assign evt.tgl = q_reg.tgl;
	assign evt.mrw = q_reg.mrw;
	assign evt.act = q_reg.act;
endmodule

// ---- bench/dram_cmd_decode_props.sv ----
module dram_cmd_decode_props (
	input wire logic clock,
	input wire logic reset,
	input wire logic ck,
	input wire logic ops_busy,
	input wire logic init_done,
	input wire logic cmd_ready,
	input wire logic dpd_active,
	input wire logic low_current,
	input wire logic rx_enable,
	input wire logic drv_enable,
	input wire logic core_pwr_enable,
	input wire logic array_lost,
	input wire logic power_on_state,
	input wire logic nop_seen,
	input wire logic mrw_valid,
	input wire logic act_valid
);
	logic ck_reg;
	logic [4:0] gap_reg;

	// Cycles since the link clock last moved, saturating
	always_ff @(posedge clock) begin
		ck_reg <= ck;
		if (ck != ck_reg)
			gap_reg <= 5'h00;
		else if (gap_reg != 5'h1f)
			gap_reg <= gap_reg + 5'h01;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	////////////////////////////////////////////////////////////////////////
	a_mrw_pulse: assert property (mrw_valid |=> !mrw_valid)
		else $error("mrw_valid longer than one cycle");
	a_act_gated: assert property (
		act_valid |-> (cmd_ready && !power_on_state) ##1 !act_valid)
		else $error("act_valid without readiness or too long");
	a_lost_entry: assert property (
		array_lost |-> (dpd_active && !rx_enable) ##1 !array_lost)
		else $error("array_lost outside deep power-down entry");
	a_rx_off: assert property (dpd_active |-> !rx_enable)
		else $error("receivers on in deep power-down");
	a_low_off: assert property (
		low_current |-> dpd_active && !drv_enable && !core_pwr_enable)
		else $error("drivers or power on at low current");
	a_drain_hold: assert property (
		dpd_active && ops_busy && !low_current |=> !low_current)
		else $error("low current reached while operations run");
	a_low_idle: assert property ($rose(low_current) |-> !$past(ops_busy))
		else $error("low current rose after busy cycle");
	a_awake_on: assert property (
		!dpd_active |-> rx_enable && drv_enable && core_pwr_enable)
		else $error("enable low outside deep power-down");
	a_init_leave: assert property (
		power_on_state && init_done |=> !power_on_state)
		else $error("power-on state kept after init_done");
	a_stop_ready: assert property (gap_reg >= 5'h14 |-> !cmd_ready)
		else $error("cmd_ready high with link clock stopped");
	a_ready_ck: assert property ($rose(cmd_ready) |-> gap_reg < 5'h08)
		else $error("cmd_ready rose without running link clock");
	a_quiet_dpd: assert property (
		low_current |-> !nop_seen && !mrw_valid && !act_valid)
		else $error("command decoded in deep power-down");
endmodule

bind dram_cmd_decode dram_cmd_decode_props dram_cmd_decode_props_i (
	.clock(clock), .reset(reset), .ck(ck), .ops_busy(ops_busy),
	.init_done(init_done), .cmd_ready(cmd_ready), .dpd_active(dpd_active),
	.low_current(low_current), .rx_enable(rx_enable),
	.drv_enable(drv_enable), .core_pwr_enable(core_pwr_enable),
	.array_lost(array_lost), .power_on_state(power_on_state),
	.nop_seen(nop_seen), .mrw_valid(mrw_valid), .act_valid(act_valid)
);

// ---- bench/ca_host_model.sv ----
module ca_host_model (
	output logic ck,
	output logic cke,
	output logic cs_n,
	output logic [dram_cmd_pkg::CA_W-1:0] ca
);
	timeunit 1ns;
	timeprecision 100ps;
	logic run = 1'b1;

	initial begin
		ck = 1'b0;
		cke = 1'b1;
		cs_n = 1'b1;
		ca = 10'h155;
	end

	// Fixed period; a stop parks the true clock low
	always #15 ck = run ? ~ck : 1'b0;
	// Deselected bus never holds a stale word
	always @(ck) #1 if (cs_n) ca = ~ca;

	task automatic cmd(input logic k, input logic c,
		input logic [dram_cmd_pkg::CA_W-1:0] r,
		input logic [dram_cmd_pkg::CA_W-1:0] f);
		@(negedge ck);
		#2;
		cke = k;
		cs_n = c;
		ca = r;
		@(posedge ck);
		#2 ca = f;
		@(negedge ck);
		#2;
		cs_n = 1'b1;
		ca = ~f;
		@(posedge ck);
	endtask

	task automatic wake();
		@(negedge ck);
		#2 cke = 1'b1;
		repeat (2) @(posedge ck);
	endtask

	// Only called idle with CS_n high; restart gives steady cycles
	task automatic halt(input int t);
		run = 1'b0;
		#t;
		run = 1'b1;
	endtask
endmodule

// ---- bench/dram_cmd_decode_dpd_clock_change_test.sv ----
module dram_cmd_decode_dpd_clock_change_test;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {
		logic [1:0] kind;
		logic [9:0] r;
		logic [9:0] f;
		logic [17:0] exp;
	} row_s;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic ops_busy = 1'b0;
	logic mr_busy = 1'b0;
	logic init_done = 1'b0;
	logic ck, cke, cs_n, cmd_ready, dpd_active, low_current, rx_enable;
	logic drv_enable, core_pwr_enable, array_lost, power_on_state;
	logic illegal_event, nop_seen, mrw_valid, act_valid;
	logic [dram_cmd_pkg::CA_W-1:0] ca;
	logic [dram_cmd_pkg::MA_W-1:0] mrw_addr;
	logic [dram_cmd_pkg::OP_W-1:0] mrw_op;
	logic [dram_cmd_pkg::BANK_W-1:0] act_bank;
	logic [dram_cmd_pkg::ROW_W-1:0] act_row;
	int errors = 0;
	int check_count = 0;
	int waited = 0;
	int n, m;
	// Pulse counts: write, activate, no-op, array lost
	int hits [4] = '{0, 0, 0, 0};
	row_s rows [7] = '{'{2'h0, 10'h050, 10'h0eb, 18'h0c53a},
		'{2'h0, 10'h3f0, 10'h003, 18'h0ff00},
		'{2'h0, 10'h000, 10'h3fc, 18'h000ff},
		'{2'h1, 10'h2aa, 10'h35c, 18'h2ea5c},
		'{2'h1, 10'h3fe, 10'h3ff, 18'h3ffff},
		'{2'h1, 10'h002, 10'h000, 18'h00000},
		'{2'h2, 10'h007, 10'h000, 18'h00000}};

	always #4 clock = ~clock;

	ca_host_model ca_host_model_i (.ck(ck), .cke(cke), .cs_n(cs_n), .ca(ca));

	dram_cmd_decode dram_cmd_decode_i (
		.clock(clock), .reset(reset), .ck(ck), .cke(cke), .cs_n(cs_n),
		.ca(ca), .ops_busy(ops_busy), .mr_busy(mr_busy),
		.init_done(init_done), .cmd_ready(cmd_ready),
		.dpd_active(dpd_active), .low_current(low_current),
		.rx_enable(rx_enable), .drv_enable(drv_enable),
		.core_pwr_enable(core_pwr_enable), .array_lost(array_lost),
		.power_on_state(power_on_state), .illegal_event(illegal_event),
		.nop_seen(nop_seen), .mrw_valid(mrw_valid), .mrw_addr(mrw_addr),
		.mrw_op(mrw_op), .act_valid(act_valid), .act_bank(act_bank),
		.act_row(act_row)
	);

	always @(posedge clock) begin
		if (mrw_valid === 1'b1) hits[0]++;
		if (act_valid === 1'b1) hits[1]++;
		if (nop_seen === 1'b1) hits[2]++;
		if (array_lost === 1'b1) hits[3]++;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		if (errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check_bit(input string s, input logic seen, input logic e);
		check_count++;
		if (seen !== e) begin
			errors++;
			$display("[FAIL] %s expected %b seen %b", s, e, seen);
		end
	endtask

	task automatic check_word(input string s, input logic [17:0] seen,
		input logic [17:0] e);
		check_count++;
		if (seen !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", s, e, seen);
		end
	endtask

	task automatic wait_hit(input int k, input int n0);
		for (int i = 0; i < 40 && hits[k] == n0; i++)
			@(negedge clock);
		if (hits[k] == n0) begin
			errors++;
			print_verdict();
		end
	endtask

	task automatic wait_for(ref logic s, input logic v);
		waited = 0;
		while (s !== v && waited < 400) begin
			@(negedge clock);
			waited++;
		end
		if (s !== v) begin
			errors++;
			print_verdict();
		end
	endtask

	task automatic pulse_init();
		@(negedge clock);
		init_done = 1'b1;
		@(negedge clock);
		init_done = 1'b0;
		@(negedge clock);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		// Longer than six cycles so the link side sees its own reset edges
		repeat (24) @(negedge clock);
		check_bit("cmd_ready", cmd_ready, 1'b0);
		check_bit("power_on_state", power_on_state, 1'b1);
		reset = 1'b0;
		wait_for(cmd_ready, 1'b1);
		n = hits[1];
		ca_host_model_i.cmd(1'b1, 1'b0, 10'h2aa, 10'h35c);
		repeat (10) @(negedge clock);
		check_bit("act_in_power_on", hits[1] == n, 1'b1);
		check_bit("illegal_event", illegal_event, 1'b1);
		pulse_init();
		check_bit("illegal_event", illegal_event, 1'b0);
		check_bit("power_on_state", power_on_state, 1'b0);
		foreach (rows[i]) begin
			n = hits[rows[i].kind];
			ca_host_model_i.cmd(1'b1, 1'b0, rows[i].r, rows[i].f);
			wait_hit(rows[i].kind, n);
			if (rows[i].kind == 2'h0)
				check_word("mrw", {2'h0, mrw_addr, mrw_op}, rows[i].exp);
			else if (rows[i].kind == 2'h1)
				check_word("act", {act_bank, act_row}, rows[i].exp);
		end
		check_bit("illegal_event", illegal_event, 1'b0);
		ops_busy = 1'b1;
		n = hits[3];
		ca_host_model_i.cmd(1'b0, 1'b0, 10'h003, 10'h000);
		wait_hit(3, n);
		check_bit("rx_enable", rx_enable, 1'b0);
		repeat (6) @(negedge clock);
		check_bit("low_current", low_current, 1'b0);
		n = hits[2];
		m = hits[1];
		ca_host_model_i.cmd(1'b0, 1'b0, 10'h3fe, 10'h3ff);
		@(negedge clock);
		ops_busy = 1'b0;
		repeat (12) @(negedge clock);
		check_bit("low_current", low_current, 1'b1);
		check_bit("core_pwr_enable", core_pwr_enable, 1'b0);
		check_bit("act_in_dpd", hits[1] == m, 1'b1);
		check_bit("nop_in_dpd", hits[2] == n, 1'b1);
		ca_host_model_i.wake();
		wait_for(power_on_state, 1'b1);
		check_bit("dpd_active", dpd_active, 1'b0);
		check_bit("drv_enable", drv_enable, 1'b1);
		pulse_init();
		ca_host_model_i.halt(200);
		check_bit("cmd_ready", cmd_ready, 1'b0);
		wait_for(cmd_ready, 1'b1);
		check_bit("ready_delay", waited >= 8, 1'b1);
		check_bit("illegal_event", illegal_event, 1'b0);
		// Settings rewrite after the clock change
		n = hits[0];
		ca_host_model_i.cmd(1'b1, 1'b0, rows[0].r, rows[0].f);
		wait_hit(0, n);
		check_word("mrw_after_stop", {2'h0, mrw_addr, mrw_op}, rows[0].exp);
		// Entry during a mode register access is flagged
		mr_busy = 1'b1;
		n = hits[3];
		ca_host_model_i.cmd(1'b0, 1'b0, 10'h003, 10'h000);
		wait_hit(3, n);
		repeat (2) @(negedge clock);
		check_bit("illegal_mr_busy", illegal_event, 1'b1);
		mr_busy = 1'b0;
		print_verdict();
	end
endmodule
